// *** include/bps_regs.svh ***
// Constants for the board power supervisor
`ifndef BPS_REGS_SVH
`define BPS_REGS_SVH

`define BPS_STAGES       8
`define BPS_CLK_MHZ      50
`define BPS_TON_MAX_US   15000
`define BPS_TOFF_STEP_US 1000
`define BPS_VIN_ON_MV    16'h2710
`define BPS_VIN_OFF_MV   16'h2328
`define BPS_TERM_STAGE   6

`define BPS_ST_W   10
`define BPS_ST_UVF 0
`define BPS_ST_UVW 1
`define BPS_ST_OVW 2
`define BPS_ST_OVF 3
`define BPS_ST_UCF 4
`define BPS_ST_OCW 5
`define BPS_ST_OCF 6
`define BPS_ST_OTW 7
`define BPS_ST_OTF 8
`define BPS_ST_TON 9

`define BPS_OT_WARN  12'h055
`define BPS_OT_FAULT 12'h064
`define BPS_UCF_1A   20'hFD8F0
`define BPS_UCF_2A   20'hFB1E0

`endif

// *** include/bps_pkg.sv ***
// Shared types for the board power supervisor
package bps_pkg;

  typedef struct packed {
    logic [15:0]        v;
    logic signed [19:0] i;
    logic signed [11:0] t;
  } bps_tele_t;

  typedef struct packed {
    logic               valid;
    logic [15:0]        uvf;
    logic [15:0]        uvw;
    logic [15:0]        ovw;
    logic [15:0]        ovf;
    logic signed [19:0] ucf;
    logic signed [19:0] ocw;
    logic signed [19:0] ocf;
    logic signed [11:0] otw;
    logic signed [11:0] otf;
  } bps_lim_t;

  typedef struct packed {
    logic o;
    logic oe;
  } bps_od_t;

  typedef enum logic [2:0] {
    BPS_RD_VOLT,
    BPS_RD_CURR,
    BPS_RD_POWER,
    BPS_RD_TEMP,
    BPS_RD_STATUS
  } bps_kind_t;

  typedef enum logic [2:0] {
    BPS_S_OFF,
    BPS_S_UP,
    BPS_S_ON,
    BPS_S_DOWN,
    BPS_S_FAULT
  } bps_seq_t;

endpackage : bps_pkg

// *** src/bps_lim_mem.sv ***
// Per-channel limit store with registered read port
`timescale 1ns/100ps
`default_nettype none
`include "bps_regs.svh"

module bps_lim_mem
  import bps_pkg::*;
#(
  parameter int DEPTH = `BPS_STAGES,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire bps_lim_t      wr_data_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output bps_lim_t           rd_data_o
);

  bps_lim_t mem_r [DEPTH];
  bps_lim_t rd_data_r;

  // Factory limits, voltage in 100 uV and current in 100 uA
  function automatic bps_lim_t lim_default(int ch);
    logic [63:0] v;
    logic [39:0] c;
    logic [19:0] uc;
    uc = (ch == 1) ? `BPS_UCF_2A : `BPS_UCF_1A;
    case (ch)
      0, 3:    v = {16'h2328, 16'h2422, 16'h29FE, 16'h2AF8};
      1, 7:    v = {16'h3F48, 16'h410A, 16'h4B96, 16'h4D58};
      2:       v = {16'h4650, 16'h4844, 16'h53FC, 16'h55F0};
      4:       v = {16'h2A30, 16'h2B5C, 16'h3264, 16'h3390};
      5:       v = {16'h7404, 16'h773D, 16'h8A93, 16'h8DCC};
      6:       v = {16'h34BC, 16'h3633, 16'h3EFD, 16'h4074};
      default: v = '0;
    endcase
    case (ch)
      0:       c = {20'h61A80, 20'h6B6C0};
      1, 5, 6: c = {20'h249F0, 20'h25D78};
      2:       c = {20'h04E20, 20'h07530};
      3:       c = {20'h13880, 20'h14C08};
      4:       c = {20'h07530, 20'h07CF8};
      7:       c = {20'h02710, 20'h02AF4};
      default: c = '0;
    endcase
    return {(ch < 8), v, uc, c, `BPS_OT_WARN, `BPS_OT_FAULT};
  endfunction : lim_default

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= lim_default(i);
      end
    end else if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= mem_r[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_r;

endmodule : bps_lim_mem
`default_nettype wire

// *** src/bps_supervisor.sv ***
// Board power sequencer and rail fault monitor
`timescale 1ns/100ps
`default_nettype none
`include "bps_regs.svh"
// Contract
// - Input above 10V, switch on: rails up in order
// - Below 9V or switch off: reverse timed shutdown
// - Sample voltage, current, temperature of every channel
// - Per-rail under/over voltage fault and warning limits
// - Per-rail undercurrent and overcurrent limits
// - Termination rails carry no checks
// - Any fault or warning pulls alert low
// - Alert on turn-on timeout of 15 ms
// - Alert held until condition gone and cleared
// - Aux fault held low until ON again
// - Channel-fault pin is output only
// - Board inverts channel-fault into faulted-off line
// - Return voltage, current, power, temperature on read
// - Checks only when channel has full limit set
////////////////////////////////////////////////////////////////////////////////

module bps_supervisor
  import bps_pkg::*;
#(
  parameter int NCH      = `BPS_STAGES,
  parameter int TON_CYC  = `BPS_TON_MAX_US * `BPS_CLK_MHZ,
  parameter int TOFF_CYC = `BPS_TOFF_STEP_US * `BPS_CLK_MHZ,
  parameter int CW       = $clog2(NCH)
) (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  input  wire logic [15:0]             vin_mv_i,
  input  wire logic                    power_switch_i,
  input  wire bps_tele_t [NCH-1:0]     tele_i,
  input  wire logic                    clear_faults_i,
  input  wire logic                    rd_req_i,
  input  wire logic [CW-1:0]           rd_chan_i,
  input  wire bps_kind_t               rd_kind_i,
  input  wire logic                    cfg_we_i,
  input  wire logic [CW-1:0]           cfg_chan_i,
  input  wire bps_lim_t                cfg_lim_i,
  input  wire logic                    supervisor_channel_fault_n_i,
  output logic [NCH-1:0]               stage_en_o,
  output logic                         term_en_o,
  output bps_od_t                      supervisor_alert_n_o,
  output bps_od_t                      supervisor_auxiliary_fault_n_o,
  output bps_od_t                      supervisor_channel_fault_n_o,
  output logic                         rd_valid_o,
  output logic [35:0]                  rd_data_o
);

  localparam logic [19:0]         TON_LAST  = 20'(TON_CYC - 1);
  localparam logic [19:0]         TOFF_LAST = 20'(TOFF_CYC - 1);
  localparam logic [CW-1:0]       TOP       = CW'(NCH - 1);
  localparam logic [CW-1:0]       TERM      = CW'(`BPS_TERM_STAGE);
  localparam logic [`BPS_ST_W-1:0] TON_MASK =
    `BPS_ST_W'(1) << `BPS_ST_TON;

  bps_seq_t               state_r;
  logic [CW-1:0]          stage_r;
  logic [CW-1:0]          scan_r;
  logic [CW-1:0]          scan_d_r;
  logic [19:0]            tmr_r;
  logic [NCH-1:0]         stage_en_r;
  logic [NCH-1:0]         pg_r;
  logic                   term_en_r;
  logic                   in_ok_r;
  logic                   faulted_r;
  logic                   aux_r;
  logic                   chf_r;
  logic                   alert_r;
  logic                   rd_valid_r;
  logic [35:0]            rd_data_r;
  bps_tele_t              samp_r;
  bps_tele_t              tele_r [NCH];
  logic [`BPS_ST_W-1:0]   act_r [NCH];
  logic [`BPS_ST_W-1:0]   st_r [NCH];
  bps_lim_t               lim_rd;
  bps_tele_t              sel;
  logic [`BPS_ST_W-1:0]   cond;
  logic signed [36:0]     pw;
  logic                   on_req;
  logic                   hard_evt;
  logic                   ton_evt;
  logic                   off_evt;
  logic                   any_st;

  function automatic logic hit(logic [CW-1:0] idx, int ch);
    return idx == CW'(ch);
  endfunction : hit

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Telemetry scan and limit compare

  bps_lim_mem #(
    .DEPTH (NCH),
    .AW    (CW)
  ) u_lim (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .wr_en_i   (cfg_we_i),
    .wr_addr_i (cfg_chan_i),
    .wr_data_i (cfg_lim_i),
    .rd_addr_i (scan_r),
    .rd_data_o (lim_rd)
  );

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      scan_r   <= '0;
      scan_d_r <= '0;
      samp_r   <= '0;
    end else begin
      scan_r   <= scan_r + 1'b1;
      scan_d_r <= scan_r;
      samp_r   <= tele_i[scan_r];
    end
  end

  chk_scan_walk: assert property (!$past(rst_i) |->
    scan_r == CW'($past(scan_r) + 1'b1))
    else $error("telemetry scan skipped a channel");

  always_comb begin
    cond = '0;
    if (lim_rd.valid && stage_en_r[scan_d_r]) begin
      cond[`BPS_ST_UVF] = pg_r[scan_d_r] && (samp_r.v < lim_rd.uvf);
      cond[`BPS_ST_UVW] = pg_r[scan_d_r] && (samp_r.v < lim_rd.uvw);
      cond[`BPS_ST_OVW] = samp_r.v > lim_rd.ovw;
      cond[`BPS_ST_OVF] = samp_r.v > lim_rd.ovf;
      cond[`BPS_ST_UCF] = samp_r.i < lim_rd.ucf;
      cond[`BPS_ST_OCW] = samp_r.i > lim_rd.ocw;
      cond[`BPS_ST_OCF] = samp_r.i > lim_rd.ocf;
      cond[`BPS_ST_OTW] = samp_r.t > lim_rd.otw;
      cond[`BPS_ST_OTF] = samp_r.t > lim_rd.otf;
    end
  end

  chk_mon_gate: assert property (!lim_rd.valid |-> cond == '0)
    else $error("check raised on channel without limits");

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pg_r <= '0;
      for (int ch = 0; ch < NCH; ch++) begin
        tele_r[ch] <= '0;
        act_r[ch]  <= '0;
      end
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (!stage_en_r[ch]) begin
          pg_r[ch] <= 1'b0;
        end
        if (hit(scan_d_r, ch)) begin
          tele_r[ch] <= samp_r;
          act_r[ch]  <= cond;
          if (stage_en_r[ch] && samp_r.v >= lim_rd.uvf) begin
            pg_r[ch] <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, alert and fault lines

  assign on_req   = in_ok_r && power_switch_i;
  assign hard_evt = cond[`BPS_ST_OVF] || cond[`BPS_ST_UCF] ||
                    cond[`BPS_ST_OCF];
  assign ton_evt  = (state_r == BPS_S_UP) && on_req && !hard_evt &&
                    !cond[`BPS_ST_OTF] && !pg_r[stage_r] &&
                    (tmr_r == TON_LAST);
  assign off_evt  = hard_evt || cond[`BPS_ST_OTF] || ton_evt;

  // Set wins over clear; clear keeps conditions still present
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int ch = 0; ch < NCH; ch++) begin
        st_r[ch] <= '0;
      end
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        st_r[ch] <= (clear_faults_i ? act_r[ch] : st_r[ch]) |
                    (hit(scan_d_r, ch) ? cond : '0) |
                    ((ton_evt && hit(stage_r, ch)) ? TON_MASK : '0);
      end
    end
  end

  always_comb begin
    any_st = 1'b0;
    for (int ch = 0; ch < NCH; ch++) begin
      any_st = any_st || (|st_r[ch]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= any_st;
    end
  end

  sequence s_alert_up;
    ##1 any_st ##1 alert_r;
  endsequence

  chk_ton_alert: assert property (ton_evt |-> s_alert_up)
    else $error("turn-on timeout did not raise alert");

  chk_alert_clear: assert property ($fell(alert_r) |->
    $past(clear_faults_i, 2))
    else $error("alert released without clear");

  chk_alert_any: assert property (any_st |=> alert_r)
    else $error("status set but alert not driven");

  ////////////////////////////////////////////////////////////////////////////
  // Input supply hysteresis and sequencer

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      in_ok_r <= 1'b0;
    end else if (vin_mv_i > `BPS_VIN_ON_MV) begin
      in_ok_r <= 1'b1;
    end else if (vin_mv_i < `BPS_VIN_OFF_MV) begin
      in_ok_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r    <= BPS_S_OFF;
      stage_r    <= '0;
      tmr_r      <= '0;
      stage_en_r <= '0;
      term_en_r  <= 1'b0;
      faulted_r  <= 1'b0;
      aux_r      <= 1'b0;
      chf_r      <= 1'b0;
    end else begin
      if (hard_evt) begin
        aux_r <= 1'b1;
      end
      if (off_evt) begin
        faulted_r <= 1'b1;
        chf_r     <= 1'b1;
      end
      case (state_r)
        BPS_S_OFF: if (on_req) begin
          state_r       <= BPS_S_UP;
          stage_r       <= '0;
          tmr_r         <= '0;
          stage_en_r[0] <= 1'b1;
          faulted_r     <= 1'b0;
          aux_r         <= 1'b0;
          chf_r         <= 1'b0;
        end
        BPS_S_UP: begin
          if (off_evt || !on_req) begin
            state_r <= BPS_S_DOWN;
            tmr_r   <= '0;
          end else if (pg_r[stage_r]) begin
            tmr_r <= '0;
            if (stage_r == TOP) begin
              state_r <= BPS_S_ON;
            end else begin
              stage_r                    <= stage_r + 1'b1;
              stage_en_r[stage_r + 1'b1] <= 1'b1;
              if (stage_r + 1'b1 == TERM) begin
                term_en_r <= 1'b1;
              end
            end
          end else begin
            tmr_r <= tmr_r + 1'b1;
          end
        end
        BPS_S_ON: if (off_evt || !on_req) begin
          state_r <= BPS_S_DOWN;
          tmr_r   <= '0;
        end
        BPS_S_DOWN: begin
          if (tmr_r == TOFF_LAST) begin
            tmr_r               <= '0;
            stage_en_r[stage_r] <= 1'b0;
            if (stage_r == TERM) begin
              term_en_r <= 1'b0;
            end
            if (stage_r == '0) begin
              state_r <= faulted_r ? BPS_S_FAULT : BPS_S_OFF;
            end else begin
              stage_r <= stage_r - 1'b1;
            end
          end else begin
            tmr_r <= tmr_r + 1'b1;
          end
        end
        BPS_S_FAULT: if (!power_switch_i) begin
          state_r <= BPS_S_OFF;
        end
        default: state_r <= BPS_S_OFF;
      endcase
    end
  end

  sequence s_step_end;
    state_r == BPS_S_DOWN && tmr_r == TOFF_LAST;
  endsequence

  chk_stage_therm: assert property
    (((stage_en_r + 1'b1) & stage_en_r) == '0)
    else $error("rail stages not enabled in order");

  chk_term_with: assert property (term_en_r == stage_en_r[TERM])
    else $error("termination rails not with memory rail");

  chk_up_gate: assert property ($rose(stage_en_r[0]) |->
    $past(in_ok_r) && $past(power_switch_i))
    else $error("power-up without supply and switch");

  chk_down_start: assert property
    ((state_r == BPS_S_ON && !on_req) |=> state_r == BPS_S_DOWN)
    else $error("shutdown not started");

  chk_down_step: assert property
    (s_step_end |=> stage_en_r < $past(stage_en_r))
    else $error("stage not dropped at step end");

  chk_down_hold: assert property
    ((state_r == BPS_S_DOWN && tmr_r != TOFF_LAST) |=>
     stage_en_r == $past(stage_en_r))
    else $error("stage dropped before its time");

  chk_aux_set: assert property (hard_evt |=> aux_r && chf_r)
    else $error("hard fault did not drive fault lines");

  chk_aux_hold: assert property
    ((aux_r && !(state_r == BPS_S_OFF && on_req)) |=> aux_r)
    else $error("aux fault released early");

  chk_chf_ignore: assert property
    ((state_r == BPS_S_ON && on_req && !off_evt) |=> state_r == BPS_S_ON)
    else $error("rails dropped without cause");

  ////////////////////////////////////////////////////////////////////////////
  // Telemetry readback

  assign sel = tele_r[rd_chan_i];

  always_comb begin
    pw = sel.i * $signed({1'b0, sel.v});
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
    end else begin
      rd_valid_r <= rd_req_i;
      if (rd_req_i) begin
        case (rd_kind_i)
          BPS_RD_VOLT:   rd_data_r <= 36'(sel.v);
          BPS_RD_CURR:   rd_data_r <= 36'(sel.i);
          BPS_RD_POWER:  rd_data_r <= pw[35:0];
          BPS_RD_TEMP:   rd_data_r <= 36'(sel.t);
          BPS_RD_STATUS: rd_data_r <= 36'(st_r[rd_chan_i]);
          default:       rd_data_r <= '0;
        endcase
      end
    end
  end

  chk_rd_answer: assert property (rd_req_i |=> rd_valid_r)
    else $error("read not answered next cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; faulted-off line is inverted on the board

  assign stage_en_o                     = stage_en_r;
  assign term_en_o                      = term_en_r;
  assign supervisor_alert_n_o           = '{o: 1'b0, oe: alert_r};
  assign supervisor_auxiliary_fault_n_o = '{o: 1'b0, oe: aux_r};
  assign supervisor_channel_fault_n_o   = '{o: 1'b0, oe: chf_r};
  assign rd_valid_o                     = rd_valid_r;
  assign rd_data_o                      = rd_data_r;

endmodule : bps_supervisor
`default_nettype wire

// *** testbench/bps_ctrl_model.sv ***
// Controller side model: pulled-up fault lines and synchronisers
`timescale 1ns/100ps
`default_nettype none

module bps_ctrl_model
  import bps_pkg::*;
(
  input  wire logic    mclk_i,
  input  wire bps_od_t alert_od_i,
  input  wire bps_od_t aux_od_i,
  input  wire bps_od_t chf_od_i,
  input  wire logic    peer_alert_i,
  input  wire logic    peer_chf_i,
  output logic         chf_line_o,
  output logic [2:0]   irq_o
);
  logic [2:0] meta_r;
  logic       alert_line;
  logic       aux_line;
  logic       off_line;

  ////////////////////////////////////////////////////////////////////////////
  // Pull-ups hold each line high unless a party sinks it
  assign alert_line = !(alert_od_i.oe && !alert_od_i.o) &&
                      !peer_alert_i;
  assign aux_line   = !(aux_od_i.oe && !aux_od_i.o);
  assign chf_line_o = !(chf_od_i.oe && !chf_od_i.o) && !peer_chf_i;
  // Transistor inverts the wired channel-fault gate
  assign off_line   = !chf_line_o;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers: bit 0 alert, bit 1 aux fault, bit 2 faulted off
  always_ff @(posedge mclk_i) begin
    meta_r <= {off_line, !aux_line, !alert_line};
    irq_o  <= meta_r;
  end
endmodule : bps_ctrl_model
`default_nettype wire

// *** testbench/tb_board_power_sequence_fault_monitor.sv ***
// Self-checking bench for the board power supervisor
`timescale 1ns/100ps
`default_nettype none
`include "bps_regs.svh"

module tb_board_power_sequence_fault_monitor
  import bps_pkg::*;
;
  localparam int TON  = 40;
  localparam int TOFF = 5;
  logic            mclk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic [15:0]     vin = 16'h0000;
  logic            sw = 1'b0;
  bps_tele_t [7:0] tele;
  logic            clr = 1'b0;
  logic            rd_req = 1'b0;
  logic [2:0]      rd_ch = 3'h0;
  bps_kind_t       rd_kind = BPS_RD_VOLT;
  logic            cfg_we = 1'b0;
  logic [2:0]      cfg_ch = 3'h0;
  bps_lim_t        cfg_lim = '0;
  logic            chf_line;
  logic            peer_alert = 1'b0;
  logic            peer_chf = 1'b0;
  logic [7:0]      stage_en;
  logic            term_en;
  logic            rd_valid;
  logic [35:0]     rd_data;
  bps_od_t         alert_od;
  bps_od_t         aux_od;
  bps_od_t         chf_od;
  logic [2:0]      irq;
  int              fails = 0;
  int              total_checks = 0;
  int              cyc = 0;
  int              last_cyc = 0;
  integer          seed = 30;
  int nom[8] = '{10000, 18000, 20000, 10000, 12000, 33000, 15000, 18000};
  int ocw[8] = '{400000, 150000, 20000, 80000, 30000, 150000, 150000, 10000};
  int ocf[8] = '{440000, 155000, 30000, 85000, 31992, 155000, 155000, 10996};
  int              vv[8];
  int              ii[8];
  int              tt[8];
  logic [7:0]      dead = 8'h00;
  logic [7:0]      exp_q[$];
  logic [7:0]      last_en = 8'h00;
  bit              mon = 1'b1;
  bit              gap_on = 1'b0;

  always #10 mclk_i = ~mclk_i;

  bps_supervisor #(.TON_CYC(TON), .TOFF_CYC(TOFF)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .vin_mv_i(vin), .power_switch_i(sw),
    .tele_i(tele), .clear_faults_i(clr), .rd_req_i(rd_req),
    .rd_chan_i(rd_ch), .rd_kind_i(rd_kind), .cfg_we_i(cfg_we),
    .cfg_chan_i(cfg_ch), .cfg_lim_i(cfg_lim),
    .supervisor_channel_fault_n_i(chf_line), .stage_en_o(stage_en),
    .term_en_o(term_en), .supervisor_alert_n_o(alert_od),
    .supervisor_auxiliary_fault_n_o(aux_od),
    .supervisor_channel_fault_n_o(chf_od), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data));

  bps_ctrl_model ctrl (
    .mclk_i(mclk_i), .alert_od_i(alert_od), .aux_od_i(aux_od),
    .chf_od_i(chf_od), .peer_alert_i(peer_alert), .peer_chf_i(peer_chf),
    .chf_line_o(chf_line), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Rail plant: an enabled live rail sits at its set voltage
  always @(negedge mclk_i) begin
    for (int k = 0; k < 8; k++) begin
      tele[k].v <= (stage_en[k] === 1'b1 && !dead[k]) ? 16'(vv[k]) : 16'h0000;
      tele[k].i <= 20'(ii[k]);
      tele[k].t <= 12'(tt[k]);
    end
  end

  // Every enable change while mon is set is compared with the modelled order
  always @(negedge mclk_i) begin
    if (!rst_i && mon && stage_en !== last_en) begin
      chk_val("stage_en", 36'(exp_q.size() ? exp_q.pop_front() : last_en),
              36'(stage_en));
      chk_bit("term_en", stage_en[6], term_en);
      if (gap_on && last_cyc != 0)
        chk_val("off_gap", 36'(TOFF), 36'(cyc - last_cyc));
      last_cyc = cyc;
      last_en = stage_en;
    end
  end

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(string nm, logic [35:0] e, logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(string nm, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %0b seen %0b", nm, e, g);
    end
  endtask : chk_bit

  function automatic int st_of(int k);
    int v;
    int i;
    v = vv[k];
    i = ii[k];
    st_of = (v < nom[k] * 90 / 100) | (v < nom[k] * 925 / 1000) << 1 |
            (v > nom[k] * 1075 / 1000) << 2 | (v > nom[k] * 110 / 100) << 3 |
            (i < (k == 1 ? -20000 : -10000)) << 4 | (i > ocw[k]) << 5 |
            (i > ocf[k]) << 6 | (tt[k] > 85) << 7 | (tt[k] > 100) << 8;
  endfunction : st_of

  function automatic logic [35:0] exp_rd(int k, bps_kind_t kd);
    longint p;
    p = longint'(ii[k]) * vv[k];
    case (kd)
      BPS_RD_VOLT:  exp_rd = 36'(vv[k]);
      BPS_RD_CURR:  exp_rd = 36'(ii[k]);
      BPS_RD_POWER: exp_rd = 36'(p);
      BPS_RD_TEMP:  exp_rd = 36'(tt[k]);
      default:      exp_rd = 36'(st_of(k));
    endcase
  endfunction : exp_rd

  task automatic rd(int k, bps_kind_t kd, logic [35:0] e);
    @(negedge mclk_i);
    rd_req = 1'b1;
    rd_ch = 3'(k);
    rd_kind = kd;
    @(negedge mclk_i);
    chk_bit("rd_valid", 1'b1, rd_valid);
    chk_val("rd_data", e, rd_data);
    rd_req = 1'b0;
  endtask : rd

  task automatic cfg_all();
    for (int k = 0; k < 8; k++) begin
      @(negedge mclk_i);
      cfg_we = 1'b1;
      cfg_ch = 3'(k);
      cfg_lim.valid = 1'b1;
      cfg_lim.uvf = 16'(nom[k] * 90 / 100);
      cfg_lim.uvw = 16'(nom[k] * 925 / 1000);
      cfg_lim.ovw = 16'(nom[k] * 1075 / 1000);
      cfg_lim.ovf = 16'(nom[k] * 110 / 100);
      cfg_lim.ucf = (k == 1) ? `BPS_UCF_2A : `BPS_UCF_1A;
      cfg_lim.ocw = 20'(ocw[k]);
      cfg_lim.ocf = 20'(ocf[k]);
      cfg_lim.otw = `BPS_OT_WARN;
      cfg_lim.otf = `BPS_OT_FAULT;
    end
    @(negedge mclk_i);
    cfg_we = 1'b0;
  endtask : cfg_all

  task automatic wait_en(logic [7:0] e, int lim);
    for (int j = 0; j < lim && stage_en !== e; j++)
      @(negedge mclk_i);
    chk_val("stage_wait", 36'(e), 36'(stage_en));
    @(negedge mclk_i);
  endtask : wait_en

  task automatic wait_irq(int b, logic lv, int lim);
    for (int j = 0; j < lim && irq[b] !== lv; j++)
      @(negedge mclk_i);
    chk_bit("irq_line", lv, irq[b]);
  endtask : wait_irq

  task automatic pulse_clr();
    @(negedge mclk_i);
    clr = 1'b1;
    @(negedge mclk_i);
    clr = 1'b0;
  endtask : pulse_clr

  task automatic power_up();
    for (int k = 0; k < 8; k++)
      exp_q.push_back(8'((1 << (k + 1)) - 1));
    wait_en(8'hFF, 300);
  endtask : power_up

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    bps_kind_t kd;
    tele = '0;
    for (int j = 0; j < 8; j++) begin
      vv[j] = nom[j];
      ii[j] = 1000;
      tt[j] = 25;
    end
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b0;
    chk_val("rst_en", 36'h0, 36'(stage_en));
    chk_bit("rst_alert", 1'b0, alert_od.oe);
    cfg_all();
    sw = 1'b1;
    vin = 16'h251C;
    repeat (30) @(negedge mclk_i);
    chk_val("low_supply", 36'h0, 36'(stage_en));
    vin = 16'h2711;
    power_up();
    chk_bit("term_quiet", 1'b0, irq[0]);
    $display("Test power_up done");
    peer_chf = 1'b1;
    peer_alert = 1'b1;
    repeat (30) @(negedge mclk_i);
    chk_val("chf_low_en", 36'hFF, 36'(stage_en));
    chk_bit("wired_alert", 1'b1, irq[0]);
    chk_bit("off_line", 1'b1, irq[2]);
    chk_bit("own_alert", 1'b0, alert_od.oe);
    peer_chf = 1'b0;
    peer_alert = 1'b0;
    $display("Test wired_lines done");
    for (int j = 0; j < 8; j++) begin
      vv[j] = nom[j] + $random(seed) % 200;
      ii[j] = $unsigned($random(seed)) % (ocw[j] / 2);
      tt[j] = 20 + $unsigned($random(seed)) % 40;
    end
    repeat (20) @(negedge mclk_i);
    for (int j = 0; j < 15; j++) begin
      k = $unsigned($random(seed)) % 8;
      kd = bps_kind_t'(j % 5);
      rd(k, kd, exp_rd(k, kd));
    end
    $display("Test telemetry done");
    ii[0] = 410000;
    wait_irq(0, 1'b1, 40);
    chk_bit("aux_warn", 1'b0, aux_od.oe);
    rd(0, BPS_RD_STATUS, exp_rd(0, BPS_RD_STATUS));
    pulse_clr();
    repeat (20) @(negedge mclk_i);
    chk_bit("alert_kept", 1'b1, irq[0]);
    ii[0] = 1000;
    repeat (20) @(negedge mclk_i);
    chk_bit("alert_noclr", 1'b1, irq[0]);
    pulse_clr();
    wait_irq(0, 1'b0, 20);
    rd(0, BPS_RD_STATUS, 36'h0);
    $display("Test warning done");
    vin = 16'h2328;
    repeat (20) @(negedge mclk_i);
    chk_val("vin_9v", 36'hFF, 36'(stage_en));
    for (int j = 7; j >= 0; j--)
      exp_q.push_back(8'((1 << j) - 1));
    last_cyc = 0;
    gap_on = 1'b1;
    vin = 16'h2327;
    wait_en(8'h00, 8 * TOFF + 40);
    gap_on = 1'b0;
    $display("Test shutdown done");
    vin = 16'h2EE0;
    power_up();
    mon = 1'b0;
    vv[3] = 12000;
    wait_irq(1, 1'b1, 40);
    chk_bit("aux_oe", 1'b1, aux_od.oe);
    wait_irq(2, 1'b1, 10);
    vv[3] = nom[3];
    repeat (12) @(negedge mclk_i);
    pulse_clr();
    repeat (20) @(negedge mclk_i);
    chk_bit("aux_held", 1'b1, irq[1]);
    chk_bit("alert_gone", 1'b0, irq[0]);
    sw = 1'b0;
    wait_en(8'h00, 400);
    sw = 1'b1;
    wait_irq(1, 1'b0, 60);
    wait_en(8'hFF, 300);
    $display("Test aux_fault done");
    sw = 1'b0;
    wait_en(8'h00, 400);
    dead[2] = 1'b1;
    sw = 1'b1;
    wait_irq(0, 1'b1, TON + 60);
    chk_bit("ton_chf", 1'b1, chf_od.oe);
    chk_bit("no_skip", 1'b0, stage_en[3]);
    rd(2, BPS_RD_STATUS, 36'h200);
    $display("Test turn_on_timeout done");
    end_sim();
  end
endmodule : tb_board_power_sequence_fault_monitor
`default_nettype wire
